// file: hw/hpt_device.sv
// Functional notes
// R1 - Access strobe low: select low, strobes differ
// R2 - Host address strobe falls before, holds past
// R3 - Host strobe low and high two clocks
// R4 - Host keeps strobe low until ready low
// R5 - Ready pin low while chip select high
// R6 - Busy at select fall while finishing transfer
// R7 - Data read fetches, ready high until loaded
// R8 - Busy after second half of data transfer; code: only after data writes and incrementing data reads
// R9 - Other accesses never raise ready
// R10 - Read data valid one clock before ready
// R11 - Drive bus only on reads, strobe low
// R12 - Write halfword captured at strobe rise
// R13 - Selects sampled at strobe or address fall
// R14 - Two halfwords form one word, second completes
`timescale 1ns/10ps
module hpt_device
  import hpt_pkg::*;
#(
  parameter int AW = 32,
  parameter int DW = 32
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  hpt_if.dev_mp              hp,
  output logic               rd_req_o,
  output logic [AW-1:0]      rd_addr_o,
  input  wire logic          rd_ack_i,
  input  wire logic [DW-1:0] rd_data_i,
  output logic               wr_valid_o,
  output logic [AW-1:0]      wr_addr_o,
  output logic [DW-1:0]      wr_data_o,
  input  wire logic          wr_ready_i
);

  if (DW != 32 || AW != 32) begin : g_bad_width
    $error("hpt_device supports only 32-bit address and data");
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [HPT_PIN_W-1:0] meta_q;
  logic [HPT_PIN_W-1:0] pin_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= {4'hf, 20'h00000};
      pin_q  <= {4'hf, 20'h00000};
    end else begin
      meta_q <= {hp.host_chip_select_n, hp.host_data_strobe_a, hp.host_data_strobe_b,
                 hp.host_addr_strobe_n, hp.host_register_select, hp.host_read_write,
                 hp.host_halfword_id, hp.host_data_bus};
      pin_q  <= meta_q;
    end
  end

  logic        cs_n_s;
  logic        as_n_s;
  logic [3:0]  sel_s;
  logic [15:0] dat_s;
  logic        strobe_n;

  assign cs_n_s   = pin_q[HPT_PIN_CS];
  assign as_n_s   = pin_q[HPT_PIN_AS];
  assign sel_s    = pin_q[HPT_PIN_SEL+1:HPT_PIN_HW];
  assign dat_s    = pin_q[HPT_PIN_DAT+15:HPT_PIN_DAT];
  assign strobe_n = ~(pin_q[HPT_PIN_DSA] ^ pin_q[HPT_PIN_DSB]) | cs_n_s;  // R1

  // ----------------------------------------------------------------
  // Select capture on address strobe fall
  // ----------------------------------------------------------------
  logic       as_prev_q;
  logic       as_lat_q;
  logic [3:0] as_sel_q;
  logic [3:0] sel_now;

  assign sel_now = as_lat_q ? as_sel_q : sel_s;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      as_prev_q <= 1'b1;
      as_lat_q  <= 1'b0;
      as_sel_q  <= 4'h0;
    end else begin
      as_prev_q <= as_n_s;
      if (as_prev_q && !as_n_s) begin
        as_lat_q <= 1'b1;  // R13
        as_sel_q <= sel_s;
      end else if (as_n_s && strobe_n) begin
        as_lat_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Halfword read mux
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [31:0] addr_q;
  logic [31:0] data_q;

  function automatic logic [15:0] rd_half(input logic [1:0] sel, input logic hw,
                                          input logic [15:0] ctrl, input logic [31:0] addr,
                                          input logic [31:0] data);
    logic [31:0] w;
    w = data;
    if (sel == HPT_SEL_CTRL) begin
      w = {ctrl, ctrl};
    end else if (sel == HPT_SEL_ADDR) begin
      w = addr;
    end
    return hw ? w[31:16] : w[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  hpt_dev_st_t st_q;
  logic        acc_q;
  logic [3:0]  acc_sel_q;
  logic [15:0] dout_q;
  logic        dout_oe_q;
  logic        ready_n_q;
  logic        rd_req_q;
  logic        buf_in_rdy;
  logic        push;
  logic        acc_rd;
  logic        acc_hw;
  logic        acc_inc;

  assign acc_rd  = acc_sel_q[1];
  assign acc_hw  = acc_sel_q[0];
  assign acc_inc = (acc_sel_q[3:2] == HPT_SEL_DATA_INC);
  assign push    = (st_q == HPT_D_PUSH) && buf_in_rdy;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q      <= HPT_D_IDLE;
      acc_q     <= 1'b0;
      acc_sel_q <= 4'h0;
      rd_req_q  <= 1'b0;
    end else begin
      case (st_q)
        HPT_D_IDLE: begin
          if (!strobe_n && !acc_q) begin
            acc_q     <= 1'b1;
            acc_sel_q <= sel_now;  // R13
            if (sel_now[1] && !sel_now[0]
                && (sel_now[3:2] == HPT_SEL_DATA || sel_now[3:2] == HPT_SEL_DATA_INC)) begin
              rd_req_q <= 1'b1;  // R7
              st_q     <= HPT_D_FETCH;
            end
          end else if (strobe_n && acc_q) begin
            acc_q <= 1'b0;
            if (acc_hw && acc_sel_q[2]) begin
              if (!acc_rd) begin
                st_q <= HPT_D_PUSH;  // R8 R14
              end else if (acc_inc) begin
                st_q <= HPT_D_INCR;  // R8
              end
            end
          end
        end
        HPT_D_FETCH: begin
          if (rd_ack_i) begin
            rd_req_q <= 1'b0;
            st_q     <= HPT_D_PRESENT;
          end
        end
        HPT_D_PRESENT: st_q <= HPT_D_IDLE;  // R10
        HPT_D_PUSH: begin
          if (buf_in_rdy) begin
            st_q <= HPT_D_IDLE;
          end
        end
        HPT_D_INCR: st_q <= HPT_D_IDLE;
        default: st_q <= HPT_D_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= HPT_CTRL_RST;
      addr_q <= HPT_ADDR_RST;
      data_q <= HPT_DATA_RST;
    end else if (st_q == HPT_D_FETCH && rd_ack_i) begin
      data_q <= rd_data_i;
    end else if ((push && acc_inc) || st_q == HPT_D_INCR) begin
      addr_q <= addr_q + HPT_ADDR_STEP;
    end else if (st_q == HPT_D_IDLE && strobe_n && acc_q && !acc_rd) begin
      if (acc_sel_q[3:2] == HPT_SEL_CTRL) begin
        ctrl_q <= dat_s;  // R12
      end else if (acc_sel_q[3:2] == HPT_SEL_ADDR) begin
        if (acc_hw) begin
          addr_q[31:16] <= dat_s;  // R12
        end else begin
          addr_q[15:0] <= dat_s;
        end
      end else if (acc_hw) begin
        data_q[31:16] <= dat_s;  // R12 R14
      end else begin
        data_q[15:0] <= dat_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data drive and ready
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_q    <= 16'h0000;
      dout_oe_q <= 1'b0;
      ready_n_q <= 1'b0;
    end else begin
      if (st_q == HPT_D_FETCH && rd_ack_i) begin
        dout_q <= rd_data_i[15:0];  // R10
      end else if (st_q == HPT_D_IDLE && !strobe_n && !acc_q) begin
        dout_q <= rd_half(sel_now[3:2], sel_now[0], ctrl_q, addr_q, data_q);
      end
      dout_oe_q <= !strobe_n && acc_q && acc_rd && (st_q != HPT_D_FETCH);  // R11
      // Busy holds until a held-off access is taken and, for a read, its data is driven
      ready_n_q <= cs_n_s ? 1'b0 : (st_q != HPT_D_IDLE)  // R5 R6 R9
                   || (ready_n_q && !strobe_n && !(acc_q && (!acc_rd || dout_oe_q)));  // R6 R10
    end
  end

  assign hp.hbus_dev_dat = dout_q;
  assign hp.hbus_dev_oe  = dout_oe_q;
  assign hp.host_ready_n = ready_n_q;
  assign rd_req_o        = rd_req_q;
  assign rd_addr_o       = addr_q;

  // ----------------------------------------------------------------
  // Two-entry write buffer
  // ----------------------------------------------------------------
  logic                head_v_q;
  logic [AW+DW-1:0]    head_q;
  logic                spare_v_q;
  logic [AW+DW-1:0]    spare_q;
  logic                pop;

  assign buf_in_rdy = !spare_v_q;
  assign pop        = head_v_q && wr_ready_i;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_v_q  <= 1'b0;
      head_q    <= '0;
      spare_v_q <= 1'b0;
      spare_q   <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!head_v_q) begin
            head_q   <= {addr_q, data_q};
            head_v_q <= 1'b1;
          end else begin
            spare_q   <= {addr_q, data_q};
            spare_v_q <= 1'b1;
          end
        end
        2'b01: begin
          if (spare_v_q) begin
            head_q    <= spare_q;
            spare_v_q <= 1'b0;
          end else begin
            head_v_q <= 1'b0;
          end
        end
        2'b11: head_q <= {addr_q, data_q};
        default: head_q <= head_q;
      endcase
    end
  end

  assign wr_valid_o = head_v_q;
  assign wr_addr_o  = head_q[AW+DW-1:DW];
  assign wr_data_o  = head_q[DW-1:0];

endmodule

// file: hw/hpt_host.sv
`timescale 1ns/10ps
module hpt_host
  import hpt_pkg::*;
#(
  parameter bit USE_AS = 1'b1
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  hpt_if.host_mp           hp,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [1:0]  cmd_sel_i,
  input  wire logic        cmd_read_i,
  input  wire logic [31:0] cmd_wdata_i,
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_data_o
);

  // ----------------------------------------------------------------
  // Ready and bus synchroniser
  // ----------------------------------------------------------------
  logic [16:0] meta_q;
  logic [16:0] sync_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 17'h00000;
      sync_q <= 17'h00000;
    end else begin
      meta_q <= {hp.host_ready_n, hp.host_data_bus};
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  hpt_host_st_t st_q;
  logic [3:0]   cnt_q;
  logic         cs_n_q;
  logic         dsa_q;
  logic         as_n_q;
  logic [1:0]   sel_q;
  logic         rw_q;
  logic         hw_q;
  logic [15:0]  hdo_q;
  logic         hoe_q;
  logic [31:0]  word_q;
  logic         cmd_ready_q;
  logic         rsp_valid_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= HPT_H_IDLE;
      cnt_q       <= 4'h0;
      cs_n_q      <= 1'b1;
      dsa_q       <= 1'b1;
      as_n_q      <= 1'b1;
      sel_q       <= HPT_SEL_CTRL;
      rw_q        <= 1'b1;
      hw_q        <= 1'b0;
      hdo_q       <= 16'h0000;
      hoe_q       <= 1'b0;
      word_q      <= 32'h0000_0000;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      case (st_q)
        HPT_H_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (cmd_valid_i && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            cs_n_q      <= 1'b0;
            as_n_q      <= ~USE_AS;  // R2
            sel_q       <= cmd_sel_i;
            rw_q        <= cmd_read_i;
            hw_q        <= 1'b0;  // R14
            word_q      <= cmd_wdata_i;
            hdo_q       <= cmd_wdata_i[15:0];
            hoe_q       <= ~cmd_read_i;
            st_q        <= HPT_H_SETUP;
          end
        end
        HPT_H_SETUP: begin
          dsa_q <= 1'b0;  // R13
          cnt_q <= 4'h0;
          st_q  <= HPT_H_STROBE;
        end
        HPT_H_STROBE: begin
          if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (cnt_q >= HPT_RDY_SETTLE_CYC && cnt_q >= HPT_STB_LOW_MIN_CYC
              && !sync_q[16]) begin
            if (rw_q) begin
              if (hw_q) begin
                word_q[31:16] <= sync_q[15:0];
              end else begin
                word_q[15:0] <= sync_q[15:0];
              end
            end
            dsa_q <= 1'b1;  // R3 R4
            cnt_q <= 4'h0;
            st_q  <= HPT_H_RELEASE;
          end
        end
        HPT_H_RELEASE: begin
          as_n_q <= 1'b1;
          hoe_q  <= 1'b0;  // R12
          cnt_q  <= 4'h1;
          st_q   <= HPT_H_GAP;
        end
        HPT_H_GAP: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= HPT_STB_HIGH_MIN_CYC) begin  // R3
            if (!hw_q) begin
              hw_q   <= 1'b1;  // R14
              as_n_q <= ~USE_AS;
              hdo_q  <= word_q[31:16];
              hoe_q  <= ~rw_q;
              st_q   <= HPT_H_SETUP;
            end else begin
              cs_n_q      <= 1'b1;
              rsp_valid_q <= 1'b1;
              st_q        <= HPT_H_IDLE;
            end
          end
        end
        default: st_q <= HPT_H_IDLE;
      endcase
    end
  end

  assign hp.host_chip_select_n   = cs_n_q;
  assign hp.host_data_strobe_a   = dsa_q;
  assign hp.host_data_strobe_b   = 1'b1;
  assign hp.host_addr_strobe_n   = as_n_q;
  assign hp.host_register_select = sel_q;
  assign hp.host_read_write      = rw_q;
  assign hp.host_halfword_id     = hw_q;
  assign hp.hbus_host_dat        = hdo_q;
  assign hp.hbus_host_oe         = hoe_q;
  assign cmd_ready_o             = cmd_ready_q;
  assign rsp_valid_o             = rsp_valid_q;
  assign rsp_data_o              = word_q;

endmodule

// file: hw/hpt_if.sv
`timescale 1ns/10ps
interface hpt_if;
  logic        host_chip_select_n;
  logic        host_data_strobe_a;
  logic        host_data_strobe_b;
  logic        host_addr_strobe_n;
  logic [1:0]  host_register_select;
  logic        host_read_write;
  logic        host_halfword_id;
  logic        host_ready_n;
  logic [15:0] hbus_host_dat;
  logic        hbus_host_oe;
  logic [15:0] hbus_dev_dat;
  logic        hbus_dev_oe;
  logic [15:0] host_data_bus;

  // ----------------------------------------------------------------
  // Bus resolution from the two enables
  // ----------------------------------------------------------------
  assign host_data_bus = hbus_dev_oe  ? hbus_dev_dat  :
                         hbus_host_oe ? hbus_host_dat : 16'h0000;

  modport dev_mp (
    input  host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    input  host_addr_strobe_n, host_register_select, host_read_write,
    input  host_halfword_id, host_data_bus,
    output host_ready_n, hbus_dev_dat, hbus_dev_oe
  );

  modport host_mp (
    output host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    output host_addr_strobe_n, host_register_select, host_read_write,
    output host_halfword_id, hbus_host_dat, hbus_host_oe,
    input  host_ready_n, host_data_bus
  );
endinterface

// file: hw/hpt_pkg.sv
package hpt_pkg;

  // ----------------------------------------------------------------
  // Register select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  HPT_SEL_CTRL     = 2'h0;
  localparam logic [1:0]  HPT_SEL_DATA_INC = 2'h1;
  localparam logic [1:0]  HPT_SEL_ADDR     = 2'h2;
  localparam logic [1:0]  HPT_SEL_DATA     = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and address step
  // ----------------------------------------------------------------
  localparam logic [15:0] HPT_CTRL_RST  = 16'h0000;
  localparam logic [31:0] HPT_ADDR_RST  = 32'h0000_0000;
  localparam logic [31:0] HPT_DATA_RST  = 32'h0000_0000;
  localparam logic [31:0] HPT_ADDR_STEP = 32'h0000_0004;
  localparam logic [15:0] HPT_BUS_IDLE  = 16'h0000;

  // ----------------------------------------------------------------
  // Timing: figures in CPU clock periods P, counts in mclk cycles
  // ----------------------------------------------------------------
  localparam int          HPT_CLK_PERIOD_PS   = 5000;
  localparam int          HPT_P_PS            = HPT_CLK_PERIOD_PS;
  localparam int          HPT_STB_LOW_MIN_P   = 2;
  localparam int          HPT_STB_HIGH_MIN_P  = 2;
  localparam int          HPT_DV_LEAD_P       = 1;
  localparam logic [3:0]  HPT_STB_LOW_MIN_CYC =
    4'((HPT_STB_LOW_MIN_P * HPT_P_PS + HPT_CLK_PERIOD_PS - 1) / HPT_CLK_PERIOD_PS);
  localparam logic [3:0]  HPT_STB_HIGH_MIN_CYC =
    4'((HPT_STB_HIGH_MIN_P * HPT_P_PS + HPT_CLK_PERIOD_PS - 1) / HPT_CLK_PERIOD_PS);
  localparam logic [3:0]  HPT_DV_LEAD_CYC =
    4'((HPT_DV_LEAD_P * HPT_P_PS) / HPT_CLK_PERIOD_PS);
  // Host waits this long after its strobe falls before trusting ready
  localparam logic [3:0]  HPT_RDY_SETTLE_CYC  = 4'h8;

  // ----------------------------------------------------------------
  // Synchronised pin bundle layout
  // ----------------------------------------------------------------
  localparam int          HPT_PIN_W    = 24;
  localparam int          HPT_PIN_CS   = 23;
  localparam int          HPT_PIN_DSA  = 22;
  localparam int          HPT_PIN_DSB  = 21;
  localparam int          HPT_PIN_AS   = 20;
  localparam int          HPT_PIN_SEL  = 18;
  localparam int          HPT_PIN_RW   = 17;
  localparam int          HPT_PIN_HW   = 16;
  localparam int          HPT_PIN_DAT  = 0;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    HPT_D_IDLE    = 5'b00001,
    HPT_D_FETCH   = 5'b00010,
    HPT_D_PRESENT = 5'b00100,
    HPT_D_PUSH    = 5'b01000,
    HPT_D_INCR    = 5'b10000
  } hpt_dev_st_t;

  typedef enum logic [4:0] {
    HPT_H_IDLE    = 5'b00001,
    HPT_H_SETUP   = 5'b00010,
    HPT_H_STROBE  = 5'b00100,
    HPT_H_RELEASE = 5'b01000,
    HPT_H_GAP     = 5'b10000
  } hpt_host_st_t;

endpackage

// file: sim/hpt_monitor.sv
`timescale 1ns/10ps
module hpt_monitor
  import hpt_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        host_chip_select_n,
  input  wire logic        host_data_strobe_a,
  input  wire logic        host_data_strobe_b,
  input  wire logic        host_addr_strobe_n,
  input  wire logic [1:0]  host_register_select,
  input  wire logic        host_read_write,
  input  wire logic        host_halfword_id,
  input  wire logic        host_ready_n,
  input  wire logic [15:0] hbus_host_dat,
  input  wire logic        hbus_host_oe,
  input  wire logic        hbus_dev_oe
);
  // ----------------------------------------------------------------
  // Combined access strobe, word-completion and fetch-lead sequences
  // ----------------------------------------------------------------
  logic acc;
  assign acc = !host_chip_select_n && (host_data_strobe_a ^ host_data_strobe_b);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_busy_end;
    acc && host_halfword_id && host_register_select[0] &&
      (!host_read_write || host_register_select == HPT_SEL_DATA_INC) ##1 !acc;
  endsequence
  sequence s_fetch_lead;
    $rose(hbus_dev_oe) && host_ready_n && !host_chip_select_n;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_ready_cs_gate:
    assert property (host_chip_select_n [*5] |-> !host_ready_n)
    else $error("ready not low while deselected");
  chk_drive_on_read:
    assert property ($rose(hbus_dev_oe) |-> acc && host_read_write)
    else $error("device drives bus outside a read access");
  chk_bus_release:
    assert property ((!acc) [*6] |-> !hbus_dev_oe)
    else $error("device still drives bus after strobe rise");
  chk_data_lead:
    assert property (s_fetch_lead |=> !host_ready_n)
    else $error("ready did not fall one clock after read data");
  chk_busy_after_word:
    assert property (s_busy_end |-> ##[1:5] host_ready_n)
    else $error("ready not high after word end");
  chk_ctrl_no_busy:
    assert property ((acc && !host_register_select[0]) [*6] ##0 !host_ready_n
      |=> !host_ready_n)
    else $error("ready rose on control or address access");
  chk_addr_strobe_wrap:
    assert property ($rose(acc) |-> !host_addr_strobe_n ##1 !host_addr_strobe_n)
    else $error("address strobe not low around strobe fall");
  chk_strobe_low_min:
    assert property ($rose(acc) |=> acc)
    else $error("strobe active for less than two clocks");
  chk_strobe_gap_min:
    assert property ($fell(acc) |=> !acc)
    else $error("strobe gap shorter than two clocks");
  chk_release_after_ready:
    assert property ($fell(acc) |-> !$past(host_ready_n))
    else $error("strobe released before ready");
  chk_select_hold:
    assert property (acc && $past(acc) |->
      $stable({host_register_select, host_read_write, host_halfword_id}))
    else $error("selects changed during access");
  chk_wdata_hold:
    assert property ($fell(acc) && !host_read_write |-> hbus_host_oe && $stable(hbus_host_dat))
    else $error("write data not held at strobe rise");
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench
  import hpt_pkg::*;
;
  logic        mclk      = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_sel   = 2'h0;
  logic        cmd_read  = 1'b0;
  logic [31:0] cmd_wdata = 32'h0;
  logic        rd_ack    = 1'b0;
  logic [31:0] rd_data   = 32'h0;
  logic        wr_ready  = 1'b0;
  logic        stall     = 1'b0;
  logic [31:0] rs        = 32'hd42d0893;
  logic [31:0] seed      = 32'hd42d0893;
  logic [3:0]  dly       = 4'h0;
  logic        cmd_ready, rsp_valid, rd_req, wr_valid;
  logic [31:0] rsp_data, rd_addr, wr_addr, wr_data, fd, fa;
  logic [63:0] wq[$];
  logic [63:0] eq[$];
  int          fails     = 0;
  int          num_checks = 0;

  always #2.5 mclk = ~mclk;

  hpt_if hpt_if_i ();
  hpt_host hpt_host_i (.mclk_i(mclk), .rst_n_i(rst_n), .hp(hpt_if_i),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_sel_i(cmd_sel),
    .cmd_read_i(cmd_read), .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data));
  hpt_device hpt_device_i (.mclk_i(mclk), .rst_n_i(rst_n), .hp(hpt_if_i),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack), .rd_data_i(rd_data),
    .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_ready_i(wr_ready));
  hpt_monitor hpt_monitor_i (.mclk_i(mclk), .rst_n_i(rst_n),
    .host_chip_select_n(hpt_if_i.host_chip_select_n),
    .host_data_strobe_a(hpt_if_i.host_data_strobe_a),
    .host_data_strobe_b(hpt_if_i.host_data_strobe_b),
    .host_addr_strobe_n(hpt_if_i.host_addr_strobe_n),
    .host_register_select(hpt_if_i.host_register_select),
    .host_read_write(hpt_if_i.host_read_write),
    .host_halfword_id(hpt_if_i.host_halfword_id),
    .host_ready_n(hpt_if_i.host_ready_n), .hbus_host_dat(hpt_if_i.hbus_host_dat),
    .hbus_host_oe(hpt_if_i.hbus_host_oe), .hbus_dev_oe(hpt_if_i.hbus_dev_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic xfer(input logic [1:0] s, input logic rd, input logic [31:0] w,
                      output logic [31:0] r);
    int n;
    cmd_sel <= s;
    cmd_read <= rd;
    cmd_wdata <= w;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 1000);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    chk("xfer done", {31'h0, rsp_valid}, 32'h1);
    r = rsp_data;
  endtask

  // ----------------------------------------------------------------
  // Memory side: random fetch latency, random write stalls
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    rs <= lfsr(rs);
    wr_ready <= !stall && rs[3];
    rd_ack <= 1'b0;
    if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
    if (rd_req && !rd_ack) begin
      dly <= dly + 4'h1;
      if (dly > {2'h0, rs[1:0]} + 4'h2) begin
        rd_ack <= 1'b1;
        rd_data <= rs;
        fd = rs;
        fa = rd_addr;
        dly <= 4'h0;
        chk("fetch busy", {31'h0, hpt_if_i.host_ready_n}, 32'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] a, w, r;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("ready idle", {31'h0, hpt_if_i.host_ready_n}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = {seed[31:2], 2'h0};
      seed = lfsr(seed);
      w = seed;
      xfer(HPT_SEL_ADDR, 1'b0, a, r);
      xfer(HPT_SEL_CTRL, 1'b0, {w[15:0], w[15:0]}, r);
      xfer(HPT_SEL_CTRL, 1'b1, 32'h0, r);
      chk("ctrl", r, {w[15:0], w[15:0]});
      xfer(HPT_SEL_ADDR, 1'b1, 32'h0, r);
      chk("addr", r, a);
      xfer(HPT_SEL_DATA, 1'b0, w, r);
      eq.push_back({a, w});
      xfer(HPT_SEL_DATA_INC, 1'b0, ~w, r);
      eq.push_back({a, ~w});
      xfer(HPT_SEL_DATA, 1'b1, 32'h0, r);
      chk("read", r, fd);
      chk("fetch addr", fa, a + HPT_ADDR_STEP);
      xfer(HPT_SEL_DATA_INC, 1'b1, 32'h0, r);
      chk("inc read", r, fd);
      xfer(HPT_SEL_ADDR, 1'b1, 32'h0, r);
      chk("inc addr", r, a + 2 * HPT_ADDR_STEP);
    end
    stall <= 1'b1;
    fork
      begin
        repeat (400) @(posedge mclk);
        chk("busy sel", {30'h0, hpt_if_i.host_chip_select_n, hpt_if_i.host_ready_n}, 32'h1);
        chk("buf hold", {31'h0, wr_valid}, 32'h1);
        stall <= 1'b0;
      end
    join_none
    for (int j = 0; j < 3; j++) begin
      xfer(HPT_SEL_DATA, 1'b0, w ^ 32'(j), r);
      eq.push_back({a + 2 * HPT_ADDR_STEP, w ^ 32'(j)});
    end
    xfer(HPT_SEL_ADDR, 1'b1, 32'h0, r);
    chk("addr after stall", r, a + 2 * HPT_ADDR_STEP);
    repeat (60) @(posedge mclk);
    chk("writes", 32'(wq.size()), 32'(eq.size()));
    foreach (eq[k]) begin
      if (k < wq.size()) begin
        chk("wr addr", wq[k][63:32], eq[k][63:32]);
        chk("wr data", wq[k][31:0], eq[k][31:0]);
      end
    end
    close_out;
  end

  initial begin
    #100000;
    fails++;
    close_out;
  end
endmodule
